// *** design/abr_address_buffer.v ***
/*
 * Address buffer top: latches the CPU address, steers it onto the
 * slot, peripheral and multiplexed DRAM address buses, supplies
 * refresh addresses, the buffered slot strobe and the coprocessor
 * fault interrupt.
 * Holds two address latches, the ownership decode, the three
 * steering paths, the DRAM row/column multiplexer and the
 * refresh counter with its capture register.
 * Assumes all inputs synchronous to sys_clk_in; two-way pins are
 * resolved outside from the output enables.
 * Assumes users accept one clock from any input to any pin, but two
 * from the refresh window to the captured refresh address, since
 * every pin output comes from a flip-flop.
 * Assumes no refresh window during a DMA cycle; if both come,
 * DMA ownership wins.
 * Assumes reset held three clocks or more, so the synchronised
 * counter clear is seen.
 * Assumes the DRAM strobe opens no later than the CPU strobe.
 * Slot bit 0 is never driven outside a refresh.
 */
`timescale 1ns/1ns
`include "abr_consts.vh"

module abr_address_buffer (
    input  wire                   sys_clk_in,
    input  wire                   rst_in,
    input  wire [`ABR_ADDR_W-1:0] cpu_addr_in,
    input  wire                   cpu_high_byte_n_in,
    input  wire                   cpu_addr_strobe_in,
    input  wire                   dram_addr_strobe_in,
    input  wire                   hold_grant_in,
    input  wire                   dma_cycle_n_in,
    input  wire                   refresh_window_n_in,
    input  wire                   refresh_pulse_n_in,
    input  wire                   row_col_select_in,
    input  wire                   copro_fault_n_in,
    input  wire [`ABR_SLOT_W-1:0] slot_addr_in,
    output reg  [`ABR_SLOT_W-1:0] slot_addr_out,
    output reg  [`ABR_SLOT_W-1:0] slot_addr_oe_out,
    input  wire                   slot_high_byte_n_in,
    output reg                    slot_high_byte_n_out,
    output reg                    slot_high_byte_n_oe_out,
    input  wire [`ABR_ADDR_W-1:0] periph_addr_in,
    output reg  [`ABR_ADDR_W-1:0] periph_addr_out,
    output reg  [`ABR_ADDR_W-1:0] periph_addr_oe_out,
    input  wire                   periph_high_byte_n_in,
    output reg                    periph_high_byte_n_out,
    output reg                    periph_high_byte_n_oe_out,
    output reg  [`ABR_DRAM_W-1:0] dram_addr_out,
    output wire                   refresh_top_bit_out,
    output reg                    slot_addr_strobe_out,
    output reg                    copro_fault_irq_out
);

    // Row/column pick from a 16-bit word whose bit 0 is address bit 1
    function [`ABR_DRAM_W-1:0] abr_ma_pick;
        input [`ABR_ADDR_W-1:0] word;
        input                   column;
        begin
            if (column) begin
                abr_ma_pick = word[`ABR_HI_TOP:`ABR_LO_TOP+1];
            end else begin
                abr_ma_pick = word[`ABR_LO_TOP:0];
            end
        end
    endfunction

    reg  [1:0]             mode;
    reg                    rst_meta_reg;
    reg                    rst_sync_reg;

    wire [`ABR_ADDR_W:0]   cpu_latched;
    wire [`ABR_ADDR_W-1:0] cpu_addr_q;
    wire                   cpu_high_byte_n_q;
    wire [`ABR_ADDR_W-1:0] dram_latched;
    wire [`ABR_CNT_W-1:0]  refresh_count;
    wire [`ABR_CNT_W-1:0]  refresh_capture;
    wire [`ABR_SLOT_W-1:0] refresh_slot_word;
    wire [`ABR_ADDR_W-1:0] slot_in_upper;

    reg  [`ABR_SLOT_W-1:0] slot_next;
    reg  [`ABR_SLOT_W-1:0] slot_oe_next;
    reg                    slot_hb_next;
    reg                    slot_hb_oe_next;
    reg  [`ABR_ADDR_W-1:0] periph_next;
    reg  [`ABR_ADDR_W-1:0] periph_oe_next;
    reg                    periph_hb_next;
    reg                    periph_hb_oe_next;
    reg  [`ABR_DRAM_W-1:0] dram_next;
    reg                    strobe_next;

    // Slot/peripheral latch, high byte enable rides in the top bit
    abr_addr_latch #(
        .W (`ABR_ADDR_W + 1)
    ) u_cpu_latch (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .strobe_in  (cpu_addr_strobe_in),
        .data_in    ({cpu_high_byte_n_in, cpu_addr_in}),
        .data_out   (cpu_latched)
    );

    assign cpu_addr_q        = cpu_latched[`ABR_ADDR_W-1:0];
    assign cpu_high_byte_n_q = cpu_latched[`ABR_ADDR_W];

    // DRAM latch is separate so an early strobe can open it sooner
    abr_addr_latch #(
        .W (`ABR_ADDR_W)
    ) u_dram_latch (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .strobe_in  (dram_addr_strobe_in),
        .data_in    (cpu_addr_in),
        .data_out   (dram_latched)
    );

    // Reset brought onto the clock before it clears the counter
    // Clear lags reset release by two clocks
    always @(posedge sys_clk_in) begin
        rst_meta_reg <= rst_in;
        rst_sync_reg <= rst_meta_reg;
    end

    // Direct reset as well, so the count starts at zero at once
    abr_refresh_counter u_refresh (
        .sys_clk_in          (sys_clk_in),
        .rst_in              (rst_in),
        .clear_in            (rst_sync_reg),
        .refresh_pulse_n_in  (refresh_pulse_n_in),
        .refresh_window_n_in (refresh_window_n_in),
        .count_out           (refresh_count),
        .capture_out         (refresh_capture)
    );

    // Live bit, not the capture, so the upper address tracks the count
    assign refresh_top_bit_out = refresh_count[`ABR_CNT_W-1];

    // Refresh slot word: upper bits low, low nine from the capture
    assign refresh_slot_word = {`ABR_FILL_RST, refresh_capture};
    assign slot_in_upper     = slot_addr_in[`ABR_SLOT_W-1:1];

    // Ownership decode; DMA wins if the far side breaks the refresh row
    always @* begin
        if (!hold_grant_in) begin
            mode = `ABR_MODE_CPU;
        end else if (!dma_cycle_n_in) begin
            mode = `ABR_MODE_DMA;
        end else if (!refresh_window_n_in) begin
            mode = `ABR_MODE_REF;
        end else begin
            mode = `ABR_MODE_MASTER;
        end
    end

    // Slot and peripheral address steering
    always @* begin
        slot_next         = `ABR_SLOT_RST;
        slot_oe_next      = `ABR_SLOT_RST;
        slot_hb_next      = 1'b1;
        slot_hb_oe_next   = 1'b0;
        periph_next       = `ABR_ADDR_RST;
        periph_oe_next    = `ABR_OE_NONE16;
        periph_hb_next    = 1'b1;
        periph_hb_oe_next = 1'b0;
        case (mode)
            `ABR_MODE_CPU: begin
                // Bit 0 left as input outside refresh
                slot_next         = {cpu_addr_q, 1'b0};
                slot_oe_next      = {`ABR_OE_ALL16, 1'b0};
                slot_hb_next      = cpu_high_byte_n_q;
                slot_hb_oe_next   = 1'b1;
                periph_next       = cpu_addr_q;
                periph_oe_next    = `ABR_OE_ALL16;
                periph_hb_next    = cpu_high_byte_n_q;
                periph_hb_oe_next = 1'b1;
            end
            `ABR_MODE_DMA: begin
                // Peripheral bus released so the DMA side can drive it
                slot_next         = {periph_addr_in, 1'b0};
                slot_oe_next      = {`ABR_OE_ALL16, 1'b0};
                slot_hb_next      = periph_high_byte_n_in;
                slot_hb_oe_next   = 1'b1;
                periph_oe_next    = `ABR_OE_NONE16;
                periph_hb_oe_next = 1'b0;
            end
            `ABR_MODE_REF: begin
                // Slot high byte left to whoever runs the refresh; peripheral high byte driven high
                slot_next         = refresh_slot_word;
                slot_oe_next      = {`ABR_OE_ALL16, 1'b1};
                slot_hb_oe_next   = 1'b0;
                periph_next       = refresh_slot_word[`ABR_SLOT_W-1:1];
                periph_oe_next    = `ABR_OE_ALL16;
                periph_hb_next    = 1'b1;
                periph_hb_oe_next = 1'b1;
            end
            `ABR_MODE_MASTER: begin
                // Slot bus left to the outside master
                slot_oe_next      = `ABR_SLOT_RST;
                slot_hb_oe_next   = 1'b0;
                periph_next       = slot_in_upper;
                periph_oe_next    = `ABR_OE_ALL16;
                periph_hb_next    = slot_high_byte_n_in;
                periph_hb_oe_next = 1'b1;
            end
            default: begin
                slot_oe_next      = `ABR_SLOT_RST;
                periph_oe_next    = `ABR_OE_NONE16;
            end
        endcase
    end

    // DRAM address multiplexer
    always @* begin
        dram_next = `ABR_DRAM_RST;
        if (mode == `ABR_MODE_CPU) begin
            // Refresh pulse is a don't-care while the CPU owns the bus
            dram_next = abr_ma_pick(dram_latched, row_col_select_in);
        end else if (mode == `ABR_MODE_REF) begin
            if (row_col_select_in) begin
                dram_next = `ABR_DRAM_RST;
            end else begin
                dram_next = {refresh_capture[0],
                             refresh_capture[`ABR_DRAM_W-1:1]};
            end
        end else if (!refresh_pulse_n_in || mode == `ABR_MODE_MASTER) begin
            dram_next = abr_ma_pick(slot_in_upper, row_col_select_in);
        end else begin
            // Slot copy of the DMA address is a clock late, so read it direct
            dram_next = abr_ma_pick(periph_addr_in, row_col_select_in);
        end
    end

    // Buffered slot strobe
    always @* begin
        case (mode)
            `ABR_MODE_CPU: begin
                strobe_next = cpu_addr_strobe_in;
            end
            `ABR_MODE_DMA: begin
                strobe_next = 1'b1;
            end
            default: begin
                // Low while another master owns the slot bus
                strobe_next = 1'b0;
            end
        endcase
    end

    // Every pin output registered; one cycle from input to pin, two for the captured refresh address
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            slot_addr_out             <= `ABR_SLOT_RST;
            slot_addr_oe_out          <= `ABR_SLOT_RST;
            slot_high_byte_n_out      <= 1'b1;
            slot_high_byte_n_oe_out   <= 1'b0;
            periph_addr_out           <= `ABR_ADDR_RST;
            periph_addr_oe_out        <= `ABR_OE_NONE16;
            periph_high_byte_n_out    <= 1'b1;
            periph_high_byte_n_oe_out <= 1'b0;
            dram_addr_out             <= `ABR_DRAM_RST;
            slot_addr_strobe_out      <= 1'b0;
            copro_fault_irq_out       <= 1'b0;
        end else begin
            slot_addr_out             <= slot_next;
            slot_addr_oe_out          <= slot_oe_next;
            slot_high_byte_n_out      <= slot_hb_next;
            slot_high_byte_n_oe_out   <= slot_hb_oe_next;
            periph_addr_out           <= periph_next;
            periph_addr_oe_out        <= periph_oe_next;
            periph_high_byte_n_out    <= periph_hb_next;
            periph_high_byte_n_oe_out <= periph_hb_oe_next;
            dram_addr_out             <= dram_next;
            slot_addr_strobe_out      <= strobe_next;
            copro_fault_irq_out       <= ~copro_fault_n_in;
        end
    end

endmodule

// *** shared/abr_consts.vh ***
/*
 * Constants for the address buffer with refresh counter: bus widths,
 * ownership mode codes, reset values and output idle levels.
 * Assumes it is included by bare name from each design file.
 */
`ifndef ABR_CONSTS_VH
`define ABR_CONSTS_VH

// Bus widths
`define ABR_ADDR_W      16
`define ABR_SLOT_W      17
`define ABR_DRAM_W      8
`define ABR_CNT_W       9

// Field positions inside a 16-bit latched word (bit 0 is address bit 1)
`define ABR_LO_TOP      7
`define ABR_HI_TOP      15

// Ownership modes, decoded from hold, DMA and refresh window inputs
`define ABR_MODE_CPU    2'h0
`define ABR_MODE_DMA    2'h1
`define ABR_MODE_REF    2'h2
`define ABR_MODE_MASTER 2'h3

// Reset values
`define ABR_CNT_RST     9'h000
`define ABR_ADDR_RST    16'h0000
`define ABR_SLOT_RST    17'h0_0000
`define ABR_DRAM_RST    8'h00
`define ABR_FILL_RST    8'h00

// Output enable groups
`define ABR_OE_ALL16    16'hFFFF
`define ABR_OE_NONE16   16'h0000

`endif

// *** design/abr_addr_latch.v ***
/*
 * Transparent address latch: passes the input while the strobe is
 * high, holds the last passed value while it is low.
 * Assumes strobe and data are synchronous to the system clock.
 */
`timescale 1ns/1ns
`include "abr_consts.vh"

module abr_addr_latch #(
    parameter W = 17
) (
    input  wire         sys_clk_in,
    input  wire         rst_in,
    input  wire         strobe_in,
    input  wire [W-1:0] data_in,
    output wire [W-1:0] data_out
);

    reg [W-1:0] hold_reg;
    reg [W-1:0] hold_next;

    always @* begin
        hold_next = hold_reg;
        if (strobe_in) begin
            hold_next = data_in;
        end
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            hold_reg <= {W{1'b0}};
        end else begin
            hold_reg <= hold_next;
        end
    end

    // Open while strobe high, so no extra cycle of delay
    assign data_out = strobe_in ? data_in : hold_reg;

endmodule

// *** design/abr_refresh_counter.v ***
/*
 * Refresh address counter with a capture register.
 * Assumes both strobes are synchronous to the clock and that the
 * counter clear arrives already synchronised.
 */
`timescale 1ns/1ns
`include "abr_consts.vh"

module abr_refresh_counter (
    input  wire                  sys_clk_in,
    input  wire                  rst_in,
    input  wire                  clear_in,
    input  wire                  refresh_pulse_n_in,
    input  wire                  refresh_window_n_in,
    output wire [`ABR_CNT_W-1:0] count_out,
    output wire [`ABR_CNT_W-1:0] capture_out
);

    reg [`ABR_CNT_W-1:0] count_reg;
    reg [`ABR_CNT_W-1:0] count_next;
    reg [`ABR_CNT_W-1:0] capture_reg;
    reg [`ABR_CNT_W-1:0] capture_next;
    reg                  pulse_n_reg;
    reg                  window_n_reg;

    wire pulse_rise;
    wire window_fall;

    assign pulse_rise  = refresh_pulse_n_in & ~pulse_n_reg;
    assign window_fall = ~refresh_window_n_in & window_n_reg;

    always @* begin
        count_next   = count_reg;
        capture_next = capture_reg;
        if (clear_in) begin
            count_next = `ABR_CNT_RST;
        end else if (pulse_rise) begin
            count_next = count_reg + 9'h001;
        end
        // Capture sees the count before this cycle's step
        if (window_fall) begin
            capture_next = count_reg;
        end
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            count_reg    <= `ABR_CNT_RST;
            capture_reg  <= `ABR_CNT_RST;
            pulse_n_reg  <= 1'b1;
            window_n_reg <= 1'b1;
        end else begin
            count_reg    <= count_next;
            capture_reg  <= capture_next;
            pulse_n_reg  <= refresh_pulse_n_in;
            window_n_reg <= refresh_window_n_in;
        end
    end

    assign count_out   = count_reg;
    assign capture_out = capture_reg;

endmodule

// *** testbench/abr_buffer_chk.sv ***
/* Port checker for the address buffer: bus direction, forwarding,
   refresh drive, strobe, fault interrupt and latch timing.
   Assumes it is bound to the top module and sees its ports by name. */
`timescale 1ns/1ns
module abr_buffer_chk (
    input wire        sys_clk_in,
    input wire        rst_in,
    input wire [15:0] cpu_addr_in,
    input wire        cpu_addr_strobe_in,
    input wire        dram_addr_strobe_in,
    input wire        hold_grant_in,
    input wire        dma_cycle_n_in,
    input wire        refresh_window_n_in,
    input wire        row_col_select_in,
    input wire        copro_fault_n_in,
    input wire [16:0] slot_addr_in,
    input wire [16:0] slot_addr_out,
    input wire [16:0] slot_addr_oe_out,
    input wire        slot_high_byte_n_out,
    input wire        slot_high_byte_n_oe_out,
    input wire [15:0] periph_addr_in,
    input wire [15:0] periph_addr_out,
    input wire [15:0] periph_addr_oe_out,
    input wire        periph_high_byte_n_in,
    input wire [7:0]  dram_addr_out,
    input wire        slot_addr_strobe_out,
    input wire        copro_fault_irq_out
);
    wire cpu = !hold_grant_in;
    wire dma = hold_grant_in && !dma_cycle_n_in;
    wire rf  = hold_grant_in && dma_cycle_n_in && !refresh_window_n_in;
    wire ms  = hold_grant_in && dma_cycle_n_in && refresh_window_n_in;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    chk_cpu_drive:
    assert property (cpu |=> periph_addr_oe_out == 16'hFFFF && slot_addr_oe_out == 17'h1_FFFE)
        else $error("cpu mode enables wrong");
    chk_dma_fwd:
    assert property (dma |=> slot_addr_out[16:1] == $past(periph_addr_in)
        && slot_high_byte_n_out == $past(periph_high_byte_n_in) && slot_addr_strobe_out)
        else $error("dma forwarding wrong");
    chk_dma_dir:
    assert property (dma |=> periph_addr_oe_out == 16'h0000 && slot_high_byte_n_oe_out)
        else $error("dma enables wrong");
    chk_ref_slot:
    assert property (rf |=> slot_addr_oe_out == 17'h1_FFFF && slot_addr_out[16:9] == 8'h00
        && !slot_high_byte_n_oe_out) else $error("refresh slot drive wrong");
    chk_mst_fwd:
    assert property (ms |=> periph_addr_out == $past(slot_addr_in[16:1])
        && slot_addr_oe_out == 17'h0_0000) else $error("master forwarding wrong");
    chk_slot0_ref:
    assert property (slot_addr_oe_out[0] && !$past(rst_in) |-> $past(rf))
        else $error("slot bit 0 driven outside refresh");
    chk_irq_follow:
    assert property (!$past(rst_in) |-> copro_fault_irq_out == !$past(copro_fault_n_in))
        else $error("fault interrupt wrong");
    chk_strobe_cpu:
    assert property (cpu |=> slot_addr_strobe_out == $past(cpu_addr_strobe_in))
        else $error("slot strobe wrong");
    chk_latch_hold:
    assert property (cpu && !cpu_addr_strobe_in && $past(cpu) && !$past(rst_in)
        |=> $stable(periph_addr_out)) else $error("latch did not hold");
    chk_dram_mux:
    assert property (cpu && dram_addr_strobe_in |=> dram_addr_out == ($past(row_col_select_in)
        ? $past(cpu_addr_in[15:8]) : $past(cpu_addr_in[7:0]))) else $error("dram mux wrong");
endmodule

// *** testbench/abr_bus_partner.sv ***
/* Far side of the two-way address lines: resolves each line from the
   outside driver and the device enable, else lets it float.
   Assumes one bit per line and enables high while driving. */
`timescale 1ns/1ns
module abr_bus_partner #(
    parameter W = 35
) (
    input  wire         sys_clk_in,
    input  wire [W-1:0] dev_val_in,
    input  wire [W-1:0] dev_oe_in,
    input  wire [W-1:0] ext_val_in,
    input  wire [W-1:0] ext_oe_in,
    output wire [W-1:0] bus_out
);
    // Floating lines show the inverse of the last level, never a stale copy
    reg [W-1:0] last_reg = {W{1'b0}};
    // Outside driver wins, since device enables lag one cycle
    assign bus_out = (ext_oe_in & ext_val_in)
        | (~ext_oe_in & dev_oe_in & dev_val_in)
        | (~ext_oe_in & ~dev_oe_in & ~last_reg);
    always @(posedge sys_clk_in) begin
        last_reg <= bus_out;
    end
endmodule

// *** testbench/tb.sv ***
/* Self-checking bench for the address buffer: random bus modes plus
   refresh counting, capture and a mid-run reset.
   Assumes the design answers one clock after each sampling edge. */
`timescale 1ns/1ns
module tb;
    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [15:0] cpu_addr_in = 16'h0000;
    logic        cpu_high_byte_n_in = 1'b1, cpu_addr_strobe_in = 1'b1;
    logic        dram_addr_strobe_in = 1'b1, hold_grant_in = 1'b0;
    logic        dma_cycle_n_in = 1'b1, refresh_window_n_in = 1'b1;
    logic        refresh_pulse_n_in = 1'b1, row_col_select_in = 1'b0;
    logic        copro_fault_n_in = 1'b1, xsh = 1'b1, xph = 1'b1;
    logic [16:0] xs = 17'h0_0000;
    logic [15:0] xp = 16'h0000, lat, dlat;
    logic [31:0] r;
    logic [8:0]  cnt, cap;
    logic [1:0]  m;
    logic        lat_hb, pp, pw;
    wire  [16:0] slot_addr_in, slot_addr_out, slot_addr_oe_out;
    wire  [15:0] periph_addr_in, periph_addr_out, periph_addr_oe_out;
    wire         slot_high_byte_n_in, slot_high_byte_n_out, slot_high_byte_n_oe_out;
    wire         periph_high_byte_n_in, periph_high_byte_n_out, periph_high_byte_n_oe_out;
    wire  [7:0]  dram_addr_out;
    wire         refresh_top_bit_out, slot_addr_strobe_out, copro_fault_irq_out;
    wire         msm = hold_grant_in & dma_cycle_n_in & refresh_window_n_in;
    wire         dmam = hold_grant_in & ~dma_cycle_n_in;
    wire  [34:0] bus;
    integer      seed = 69, errors = 0, n_compared = 0, cycles = 0, i, k;
    abr_address_buffer i_abr_address_buffer (.*);
    abr_bus_partner #(.W(35)) i_abr_bus_partner (
        .sys_clk_in (sys_clk_in),
        .dev_val_in ({slot_addr_out, slot_high_byte_n_out, periph_addr_out,
                      periph_high_byte_n_out}),
        .dev_oe_in  ({slot_addr_oe_out, slot_high_byte_n_oe_out, periph_addr_oe_out,
                      periph_high_byte_n_oe_out}),
        .ext_val_in ({xs, xsh, xp, xph}),
        .ext_oe_in  ({{18{msm}}, {17{dmam}}}),
        .bus_out    (bus)
    );
    assign {slot_addr_in, slot_high_byte_n_in, periph_addr_in, periph_high_byte_n_in} = bus;
    always #25 sys_clk_in = ~sys_clk_in;
    // Run needs about 1250 cycles
    always @(posedge sys_clk_in) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            errors = errors + 1;
            results;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task do_reset(input integer n);
        rst_in = 1'b1;
        repeat (n) @(posedge sys_clk_in);
        #5;
        rst_in = 1'b0;
        cnt = 9'h000;
        cap = 9'h000;
        pp = 1'b1;
        pw = 1'b1;
    endtask
    // One edge: update the reference model, then compare
    task step;
        @(posedge sys_clk_in);
        #5;
        m = !hold_grant_in ? 2'd0 : !dma_cycle_n_in ? 2'd1 : !refresh_window_n_in ? 2'd2 : 2'd3;
        if (cpu_addr_strobe_in)
            {lat_hb, lat} = {cpu_high_byte_n_in, cpu_addr_in};
        if (dram_addr_strobe_in)
            dlat = cpu_addr_in;
        if (pw && !refresh_window_n_in)
            cap = cnt;
        if (!pp && refresh_pulse_n_in)
            cnt = cnt + 9'h001;
        chk(refresh_top_bit_out, cnt[8]);
        chk(copro_fault_irq_out, !copro_fault_n_in);
        chk(periph_high_byte_n_oe_out, m != 2'd1);
        case (m)
            2'd0: begin
                chk({slot_addr_out, slot_high_byte_n_out}, {lat, 1'b0, lat_hb});
                chk({periph_addr_out, periph_high_byte_n_out}, {lat, lat_hb});
                chk(dram_addr_out, row_col_select_in ? dlat[15:8] : dlat[7:0]);
                chk(slot_addr_strobe_out, cpu_addr_strobe_in);
            end
            2'd1: chk({slot_addr_out[16:1], slot_high_byte_n_out, slot_addr_strobe_out},
                      {xp, xph, 1'b1});
            2'd2: if (!pw) begin
                chk(slot_addr_out, {8'h00, cap});
                chk(dram_addr_out, row_col_select_in ? 8'h00 : {cap[0], cap[7:1]});
            end
            default: begin
                chk({periph_addr_out, periph_high_byte_n_out}, {xs[16:1], xsh});
                chk(dram_addr_out, row_col_select_in ? xs[16:9] : xs[8:1]);
            end
        endcase
        pp = refresh_pulse_n_in;
        pw = refresh_window_n_in;
    endtask
    // Counts n pulses, then a refresh window with pulses inside it
    task ref_run(input integer n);
        {hold_grant_in, dma_cycle_n_in, refresh_window_n_in, row_col_select_in} = 4'b1110;
        repeat (2) step;
        repeat (n) begin
            refresh_pulse_n_in = 1'b0;
            step;
            refresh_pulse_n_in = 1'b1;
            step;
        end
        refresh_window_n_in = 1'b0;
        repeat (2) step;
        row_col_select_in = 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            refresh_pulse_n_in = k[0];
            step;
        end
        row_col_select_in = 1'b0;
        step;
        refresh_window_n_in = 1'b1;
        step;
    endtask
    initial begin
        do_reset(16);
        for (i = 0; i < 600; i = i + 1) begin
            k = $unsigned($random(seed)) % 3;
            hold_grant_in = (k != 0);
            dma_cycle_n_in = (k != 1);
            r = $random(seed);
            cpu_addr_in = r[31:16];
            {cpu_high_byte_n_in, cpu_addr_strobe_in} = r[2:1];
            dram_addr_strobe_in = r[0] | r[1];
            {row_col_select_in, copro_fault_n_in, refresh_pulse_n_in} = r[5:3];
            {xsh, xph} = r[9:8];
            // Strobes open first so the model never guesses latch reset contents
            if (i == 0)
                {cpu_addr_strobe_in, dram_addr_strobe_in} = 2'b11;
            if (k != 2 || i < 3)
                refresh_pulse_n_in = 1'b1;
            r = $random(seed);
            xs = r[16:0];
            xp = r[31:16];
            step;
        end
        ref_run(300);
        do_reset(4);
        ref_run(3);
        results;
    end
endmodule
bind abr_address_buffer abr_buffer_chk i_chk (.*);
